// ===== rtl/rtpi_pkg.sv
package rtpi_pkg;
    // ****************************************
    // Register map (index, byte address = 4 x index)
    // ****************************************
    localparam int IDX_W = 4;
    localparam logic [IDX_W-1:0] CTRL_STAT_IDX = 4'h8;
    localparam logic [IDX_W-1:0] COUNT_IDX = 4'h9;
    localparam logic [IDX_W-1:0] CLK_SEL_IDX = 4'ha;
    localparam int IDX_LSB = 2;

    // ****************************************
    // Control/status field layout
    // ****************************************
    localparam int OVF_FLAG_BIT = 7;
    localparam int PER_FLAG_BIT = 6;
    localparam int OVF_EN_BIT = 5;
    localparam int PER_EN_BIT = 4;
    localparam int OVF_ACK_BIT = 3;
    localparam int PER_ACK_BIT = 2;
    localparam int RATE_MSB = 1;
    localparam int RATE_LSB = 0;
    localparam int SRC_SEL_BIT = 0;
    localparam logic [1:0] RATE_RESET = 2'h3;
    localparam int REG_W = 8;
    localparam int DATA_W = 32;

    // ****************************************
    // Timer chain shape
    // ****************************************
    localparam int CHAIN_W = 17;
    localparam int PRESCALE_W = 2;
    localparam int COUNT_W = 8;
    localparam int OVF_W = PRESCALE_W + COUNT_W;
    localparam int PER_BASE_W = 14;
    localparam logic [CHAIN_W-1:0] POR_CYCLES = 17'h00fe0;

    // ****************************************
    // AHB-Lite codes
    // ****************************************
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;
endpackage

// ===== rtl/rtpi_sync.sv
`timescale 1ns/100ps
module rtpi_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] first;
        logic [W-1:0] second;
    } rtpi_sync_type;

    rtpi_sync_type sync_q;
    rtpi_sync_type sync_d;

    // First stage feeds only the second stage
    always_comb begin
        sync_d.first = async_in;
        sync_d.second = sync_q.first;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_q <= {INIT, INIT};
        end else begin
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q.second;
endmodule

// ===== rtl/rtpi_ahb_slave.sv
`timescale 1ns/100ps
module rtpi_ahb_slave (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic wr_en,
    output logic [rtpi_pkg::IDX_W-1:0] reg_idx,
    output logic [rtpi_pkg::REG_W-1:0] wr_data,
    input wire logic [rtpi_pkg::REG_W-1:0] rd_data
);
    typedef struct packed {
        logic wr_pend;
        logic rd_pend;
        logic [rtpi_pkg::IDX_W-1:0] idx;
        logic [31:0] rdata;
    } rtpi_slv_type;

    rtpi_slv_type slv_q;
    rtpi_slv_type slv_d;
    logic take;

    // Reads cost one wait state so the data comes from a flop
    // and already sees a write made in the cycle before.
    always_comb begin
        slv_d = slv_q;
        take = hsel && (htrans == rtpi_pkg::HTRANS_NONSEQ) && hready;
        slv_d.wr_pend = 1'b0;
        if (slv_q.rd_pend) begin
            slv_d.rd_pend = 1'b0;
            slv_d.rdata = {{(32 - rtpi_pkg::REG_W){1'b0}}, rd_data};
        end
        if (take) begin
            slv_d.idx = haddr[rtpi_pkg::IDX_LSB +: rtpi_pkg::IDX_W];
            slv_d.wr_pend = hwrite;
            slv_d.rd_pend = !hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slv_q <= '0;
        end else begin
            slv_q <= slv_d;
        end
    end

    assign hreadyout = !slv_q.rd_pend;
    assign hresp = rtpi_pkg::HRESP_OKAY;
    assign hrdata = slv_q.rdata;
    assign wr_en = slv_q.wr_pend;
    assign reg_idx = slv_q.idx;
    assign wr_data = hwdata[rtpi_pkg::REG_W-1:0];
endmodule

// ===== rtl/rtpi_timer.sv
// What this block does
// - Bus clock through divide-by-four prescaler drives an 8-bit counter.
// - Count register at index 9 shows the 8-bit counter at any time.
// - Overflow flag sets when the 8-bit counter wraps to zero outside the power-on hold.
// - Overflow events come every 1024 bus-clock periods.
// - Power-on hold lasts 4064 bus cycles, then chain clears again.
// - Rate field picks periods 2^14, 2^15, 2^16 or 2^17 cycles.
// - Periodic flag sets when the selected rate tap fires.
// - Interrupt requested while overflow flag and its enable are set.
// - Interrupt requested while periodic flag and its enable are set.
// - Overflow flag cleared by writing one to its ack; acks read zero.
// - Periodic flag cleared by writing one to its ack bit.
// - Reset clears flags and enables and selects the slowest rate.
// - Count register is read-only; writes leave the counter alone.
// - External reset outside power-on clears the whole chain.
// - Power-on clears and starts the chain; counting resumes from zero.
// - Source select clear uses crystal divided by two, set uses synthesizer.
// - Stop mode halts counting and keeps all control and status bits.
// - Wait mode keeps counting and interrupts stay live.
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/100ps
module rtpi_timer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic xtal_clk_pin,
    input wire logic synth_clk_pin,
    input wire logic stop_mode_pin,
    input wire logic wait_mode_pin,
    input wire logic ext_reset_n_pin,
    output logic timer_irq,
    output logic por_reset_n
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [rtpi_pkg::CHAIN_W-1:0] chain;
        logic por_active;
        logic overflow_flag;
        logic periodic_flag;
        logic overflow_irq_en;
        logic periodic_irq_en;
        logic [1:0] periodic_rate_sel;
        logic bus_clk_source_sel;
        logic xtal_half;
        logic xtal_prev;
        logic synth_prev;
        logic irq;
        logic [rtpi_pkg::CHAIN_W-1:0] tick_gap;
    } rtpi_state_type;

    rtpi_state_type st_q;
    rtpi_state_type st_d;

    logic xtal_s;
    logic synth_s;
    logic stop_s;
    logic wait_s;
    logic ext_rst_n_s;
    logic wr_en;
    logic [rtpi_pkg::IDX_W-1:0] reg_idx;
    logic [rtpi_pkg::REG_W-1:0] wr_data;
    logic [rtpi_pkg::REG_W-1:0] rd_data;
    logic bus_tick;
    logic chain_run;
    logic ovf_evt;
    logic per_evt;
    logic ext_clear;
    logic wr_ctrl;
    logic ovf_ack;
    logic per_ack;
    logic [2:0] unused_size;

    assign unused_size = hsize;

    // True when the lowest n bits of the chain are all ones
    function automatic logic low_ones(input logic [rtpi_pkg::CHAIN_W-1:0] v, input int n);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < rtpi_pkg::CHAIN_W; i++) begin
            if (i < n && !v[i]) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    // ****************************************
    // Pin synchronisers and bus slave
    // ****************************************
    rtpi_sync #(
        .W(5),
        .INIT(5'h10)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in({ext_reset_n_pin, wait_mode_pin, stop_mode_pin, synth_clk_pin, xtal_clk_pin}),
        .sync_out({ext_rst_n_s, wait_s, stop_s, synth_s, xtal_s})
    );

    rtpi_ahb_slave u_slave (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .wr_en(wr_en),
        .reg_idx(reg_idx),
        .wr_data(wr_data),
        .rd_data(rd_data)
    );

    // ****************************************
    // Bus clock and chain enables
    // ****************************************
    always_comb begin
        // Crystal path ticks on every second crystal rising edge
        if (st_q.bus_clk_source_sel) begin
            bus_tick = synth_s && !st_q.synth_prev;
        end else begin
            bus_tick = xtal_s && !st_q.xtal_prev && st_q.xtal_half;
        end
        // Wait mode deliberately not gated: timer keeps running
        chain_run = bus_tick && !stop_s;
        ovf_evt = chain_run && !st_q.por_active && low_ones(st_q.chain, rtpi_pkg::OVF_W);
        per_evt = chain_run && !st_q.por_active
            && low_ones(st_q.chain, rtpi_pkg::PER_BASE_W + int'(st_q.periodic_rate_sel));
        ext_clear = !ext_rst_n_s && !st_q.por_active;
        wr_ctrl = wr_en && (reg_idx == rtpi_pkg::CTRL_STAT_IDX);
        ovf_ack = wr_ctrl && wr_data[rtpi_pkg::OVF_ACK_BIT];
        per_ack = wr_ctrl && wr_data[rtpi_pkg::PER_ACK_BIT];
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_d = st_q;
        st_d.xtal_prev = xtal_s;
        st_d.synth_prev = synth_s;
        if (xtal_s && !st_q.xtal_prev) begin
            st_d.xtal_half = !st_q.xtal_half;
        end
        if (chain_run) begin
            st_d.chain = st_q.chain + rtpi_pkg::CHAIN_W'(1);
            // Own tick count for the checks, so they do not just re-read the chain
            st_d.tick_gap = st_q.tick_gap + rtpi_pkg::CHAIN_W'(1);
        end
        if (st_q.por_active && chain_run && st_q.chain == rtpi_pkg::POR_CYCLES - 1'b1) begin
            st_d.por_active = 1'b0;
            st_d.chain = '0;
            st_d.tick_gap = '0;
        end
        if (wr_ctrl) begin
            st_d.overflow_irq_en = wr_data[rtpi_pkg::OVF_EN_BIT];
            st_d.periodic_irq_en = wr_data[rtpi_pkg::PER_EN_BIT];
            st_d.periodic_rate_sel = wr_data[rtpi_pkg::RATE_MSB:rtpi_pkg::RATE_LSB];
        end
        if (wr_en && reg_idx == rtpi_pkg::CLK_SEL_IDX) begin
            st_d.bus_clk_source_sel = wr_data[rtpi_pkg::SRC_SEL_BIT];
        end
        // Count register writes fall through with no effect
        if (ovf_ack) begin
            st_d.overflow_flag = 1'b0;
        end
        if (per_ack) begin
            st_d.periodic_flag = 1'b0;
        end
        // Sets after clears so a coinciding event is kept
        if (ovf_evt) begin
            st_d.overflow_flag = 1'b1;
            st_d.tick_gap = '0;
        end
        if (per_evt) begin
            st_d.periodic_flag = 1'b1;
        end
        if (ext_clear) begin
            st_d.chain = '0;
            st_d.tick_gap = '0;
            st_d.overflow_flag = 1'b0;
            st_d.periodic_flag = 1'b0;
            st_d.overflow_irq_en = 1'b0;
            st_d.periodic_irq_en = 1'b0;
            st_d.periodic_rate_sel = rtpi_pkg::RATE_RESET;
            st_d.bus_clk_source_sel = 1'b0;
        end
        st_d.irq = (st_d.overflow_flag && st_d.overflow_irq_en)
            || (st_d.periodic_flag && st_d.periodic_irq_en);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
            st_q.por_active <= 1'b1;
            st_q.periodic_rate_sel <= rtpi_pkg::RATE_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    always_comb begin
        rd_data = '0;
        unique case (reg_idx)
            rtpi_pkg::CTRL_STAT_IDX: begin
                // Ack bits stay zero on read
                rd_data[rtpi_pkg::OVF_FLAG_BIT] = st_q.overflow_flag;
                rd_data[rtpi_pkg::PER_FLAG_BIT] = st_q.periodic_flag;
                rd_data[rtpi_pkg::OVF_EN_BIT] = st_q.overflow_irq_en;
                rd_data[rtpi_pkg::PER_EN_BIT] = st_q.periodic_irq_en;
                rd_data[rtpi_pkg::RATE_MSB:rtpi_pkg::RATE_LSB] = st_q.periodic_rate_sel;
            end
            rtpi_pkg::COUNT_IDX: begin
                rd_data = st_q.chain[rtpi_pkg::PRESCALE_W +: rtpi_pkg::COUNT_W];
            end
            rtpi_pkg::CLK_SEL_IDX: begin
                rd_data[rtpi_pkg::SRC_SEL_BIT] = st_q.bus_clk_source_sel;
            end
            default: begin
                rd_data = '0;
            end
        endcase
    end

    assign timer_irq = st_q.irq;
    assign por_reset_n = !st_q.por_active;

    // ****************************************
    // Checks
    // ****************************************
    a_ovf_sets: assert property (@(posedge hclk) disable iff (!hresetn)
        ovf_evt && !ext_clear |=> st_q.overflow_flag && st_q.chain[rtpi_pkg::OVF_W-1:0] == '0)
        else $error("overflow flag not set on counter wrap");

    a_ovf_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
        ovf_evt |-> st_q.tick_gap[rtpi_pkg::OVF_W-1:0] == '1
        && st_q.tick_gap[rtpi_pkg::CHAIN_W-1:rtpi_pkg::OVF_W] == '0)
        else $error("overflow event off the 1024-cycle boundary");

    a_por_release: assert property (@(posedge hclk) disable iff (!hresetn)
        st_q.por_active && chain_run && st_q.chain == rtpi_pkg::POR_CYCLES - 1'b1
        |=> !st_q.por_active && st_q.chain == '0 ##1 por_reset_n)
        else $error("power-on hold not released after 4064 cycles");

    a_por_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(st_q.por_active) |-> $past(st_q.tick_gap) == rtpi_pkg::POR_CYCLES - 1'b1)
        else $error("power-on hold released early");

    a_per_sets: assert property (@(posedge hclk) disable iff (!hresetn)
        chain_run && !st_q.por_active && !ext_clear
        && low_ones(st_q.chain, rtpi_pkg::PER_BASE_W + int'(st_q.periodic_rate_sel))
        |=> st_q.periodic_flag)
        else $error("periodic flag missed its tap");

    a_irq_drops: assert property (@(posedge hclk) disable iff (!hresetn)
        ovf_ack && !ovf_evt && !per_evt
        && !(st_q.periodic_flag && wr_data[rtpi_pkg::PER_EN_BIT])
        |=> !timer_irq)
        else $error("interrupt did not drop after overflow acknowledge");

    a_per_drop: assert property (@(posedge hclk) disable iff (!hresetn)
        per_ack && !per_evt && !ovf_evt
        && !(st_q.overflow_flag && wr_data[rtpi_pkg::OVF_EN_BIT])
        |=> !timer_irq)
        else $error("interrupt did not drop after periodic acknowledge");

    a_irq_raise: assert property (@(posedge hclk) disable iff (!hresetn)
        st_q.overflow_flag && st_q.overflow_irq_en && !wr_ctrl && !ext_clear
        |=> timer_irq)
        else $error("overflow interrupt not requested");

    a_per_raise: assert property (@(posedge hclk) disable iff (!hresetn)
        st_q.periodic_flag && st_q.periodic_irq_en && !wr_ctrl && !ext_clear
        |=> timer_irq)
        else $error("periodic interrupt not requested");

    a_ovf_ack: assert property (@(posedge hclk) disable iff (!hresetn)
        ovf_ack && !ovf_evt && !ext_clear |=> !st_q.overflow_flag)
        else $error("overflow acknowledge did not clear flag");

    a_per_ack: assert property (@(posedge hclk) disable iff (!hresetn)
        st_q.periodic_flag && !per_ack && !ext_clear |=> st_q.periodic_flag)
        else $error("periodic flag cleared without acknowledge");

    a_ext_reset: assert property (@(posedge hclk) disable iff (!hresetn)
        ext_clear |=> st_q.chain == '0 && st_q.periodic_rate_sel == rtpi_pkg::RATE_RESET
        && !st_q.overflow_flag && !st_q.periodic_irq_en)
        else $error("external reset did not clear the timer");

    a_count_ro: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_en && reg_idx == rtpi_pkg::COUNT_IDX && !chain_run && !ext_clear
        |=> $stable(st_q.chain))
        else $error("write changed the count");

    a_stop_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        stop_s && !ext_clear && !wr_en |=> $stable(st_q.chain) && $stable(st_q.overflow_flag))
        else $error("timer moved in stop mode");

    a_wait_runs: assert property (@(posedge hclk) disable iff (!hresetn)
        wait_s && bus_tick && !stop_s && !ext_clear && !st_q.por_active
        |=> st_q.chain != $past(st_q.chain))
        else $error("timer stalled in wait mode");

    a_ovf_rise: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(st_q.overflow_flag) |-> $past(ovf_evt))
        else $error("overflow flag set without a wrap");

    a_per_rise: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(st_q.periodic_flag) |-> $past(per_evt))
        else $error("periodic flag set without its tap");

    a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
        !st_q.overflow_flag && !st_q.periodic_flag |-> !timer_irq)
        else $error("interrupt requested with no flag set");

    a_stop_ctrl: assert property (@(posedge hclk) disable iff (!hresetn)
        stop_s && !wr_en && !ext_clear |=> $stable(st_q.periodic_flag)
        && $stable(st_q.overflow_irq_en) && $stable(st_q.periodic_irq_en)
        && $stable(st_q.periodic_rate_sel))
        else $error("control bits moved in stop mode");

    // One wait state on reads keeps the read data coming from a flop
    a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        hsel && htrans == rtpi_pkg::HTRANS_NONSEQ && hready && !hwrite
        |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    a_write_nowait: assert property (@(posedge hclk) disable iff (!hresetn)
        hsel && htrans == rtpi_pkg::HTRANS_NONSEQ && hready && hwrite
        |=> hreadyout)
        else $error("write stalled the bus");
endmodule

// ===== sim/rtpi_cpu_model.sv
`timescale 1ns/100ps
module rtpi_cpu_model (
    input wire logic hclk,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    // ****************************************
    // Processor side of the register bus
    // ****************************************
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 20) begin
                rtpi_timer_bench.err_total++;
                rtpi_timer_bench.end_of_test();
            end
            @(posedge hclk);
        end
    endtask

    // Write data scrambled outside write data phases, so stale data never matches
    task automatic access(input logic wr, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= rtpi_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        hwdata <= ~hwdata;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wr ? d : ~hwdata;
        wait_ready();
        q = hrdata;
    endtask
endmodule

// ===== sim/rtpi_timer_bench.sv
`timescale 1ns/100ps
module rtpi_timer_bench;
    // ****************************************
    // Clocks, pins and wiring
    // ****************************************
    localparam logic [31:0] CTRL = {26'h0, rtpi_pkg::CTRL_STAT_IDX, 2'h0};
    localparam logic [31:0] CNT = {26'h0, rtpi_pkg::COUNT_IDX, 2'h0};
    localparam logic [31:0] SEL = {26'h0, rtpi_pkg::CLK_SEL_IDX, 2'h0};
    localparam logic [31:0] NONE = 32'h0000003c;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic xtal_clk_pin = 1'b0;
    logic synth_clk_pin = 1'b0;
    logic stop_mode_pin = 1'b0;
    logic wait_mode_pin = 1'b0;
    logic ext_reset_n_pin = 1'b1;
    logic hsel, hwrite, hready, hresp, timer_irq, por_reset_n;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, q, c1;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    int t_por = 0;
    logic [2:0] pin_ph = 3'h0;

    always #20 hclk = ~hclk;
    // Pin clocks stepped on hclk; synthesizer period four hclk cycles, crystal period eight
    always @(posedge hclk) begin
        pin_ph <= pin_ph + 3'h1;
        synth_clk_pin <= pin_ph[1];
        xtal_clk_pin <= pin_ph[2];
    end
    always @(posedge hclk) cyc <= cyc + 1;

    rtpi_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .xtal_clk_pin(xtal_clk_pin), .synth_clk_pin(synth_clk_pin),
        .stop_mode_pin(stop_mode_pin), .wait_mode_pin(wait_mode_pin),
        .ext_reset_n_pin(ext_reset_n_pin), .timer_irq(timer_irq),
        .por_reset_n(por_reset_n));
    rtpi_cpu_model cpu (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic end_of_test();
        if (err_total == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic in_range(input string what, input int v, input int lo, input int hi);
        check(what, {31'h0, v >= lo && v <= hi}, 32'h1);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        cpu.access(1'b1, a, d, x);
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        cpu.access(1'b0, a, 32'h0, d);
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // Irq level once the edge ending a write has landed
    task automatic irq_now(input logic e);
        #1;
        check("timer_irq", {31'h0, timer_irq}, {31'h0, e});
        @(posedge hclk);
    endtask

    // Waits for por_reset_n (which 0) or timer_irq (which 1) to read high
    task automatic wait_sig(input bit which, output int t);
        int n;
        n = 0;
        @(posedge hclk);
        while ((which ? timer_irq : por_reset_n) !== 1'b1) begin
            n++;
            if (n > 70000) begin
                err_total++;
                end_of_test();
            end
            @(posedge hclk);
        end
        t = cyc;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        int t;
        repeat (12) @(posedge hclk);
        check("irq in reset", {31'h0, timer_irq}, 32'h0);
        check("por in reset", {31'h0, por_reset_n}, 32'h0);
        hresetn <= 1'b1;
        t_por = cyc;
        @(posedge hclk);
        rd(CTRL, q);
        check("ctrl reset", q, 32'h03);
        check("hresp", {31'h0, hresp}, {31'h0, rpi_okay()});
        wr(SEL, 32'h1);
        rd(SEL, q);
        check("source sel", q, 32'h1);
        rd(NONE, q);
        check("unmapped", q, 32'h0);
        for (int r = 0; r < 4; r++) begin
            wr(CTRL, 32'(r));
            rd(CTRL, q);
            check("rate code", q, 32'(r));
        end
        wr(CTRL, 32'h23);
        wait_sig(1'b0, t);
        in_range("power-on hold", t - t_por, 16240, 16272);
        t_por = t;
        rd(CNT, q);
        check("count from zero", q, 32'h0);
        wait_sig(1'b1, t);
        in_range("overflow period", t - t_por, 4088, 4104);
        rd(CTRL, q);
        check("overflow flag", q, 32'ha3);
        rd(CNT, q);
        check("count wrapped", q, 32'h0);
        wr(CTRL, 32'h2b);
        irq_now(1'b0);
        rd(CTRL, q);
        check("ack reads zero", q, 32'h23);
        // Rate moved to the fastest tap long before its first timeout
        wr(CTRL, 32'h10);
        wait_sig(1'b1, t);
        in_range("periodic period", t - t_por, 65528, 65544);
        rd(CTRL, q);
        check("periodic flag", q, 32'hd0);
        wr(CTRL, 32'h14);
        irq_now(1'b0);
        rd(CTRL, q);
        check("periodic ack", q, 32'h90);
        stop_mode_pin <= 1'b1;
        cycles(8);
        rd(CNT, c1);
        cycles(100);
        rd(CNT, q);
        check("stop count", q, c1);
        rd(CTRL, q);
        check("stop status", q, 32'h90);
        stop_mode_pin <= 1'b0;
        wait_mode_pin <= 1'b1;
        cycles(8);
        rd(CNT, c1);
        wr(CNT, {24'h0, c1[7:0] ^ 8'h80});
        cycles(60);
        rd(CNT, q);
        in_range("count rate", int'(q[7:0] - c1[7:0]), 3, 5);
        wr(SEL, 32'h0);
        cycles(16);
        rd(CNT, c1);
        cycles(317);
        rd(CNT, q);
        in_range("crystal rate", int'(q[7:0] - c1[7:0]), 4, 6);
        wr(SEL, 32'h1);
        wr(CTRL, 32'h30);
        ext_reset_n_pin <= 1'b0;
        cycles(8);
        ext_reset_n_pin <= 1'b1;
        cycles(2);
        rd(CNT, q);
        check("ext reset count", q, 32'h0);
        check("por kept", {31'h0, por_reset_n}, 32'h1);
        rd(CTRL, q);
        check("ext reset ctrl", q, 32'h03);
        rd(SEL, q);
        check("ext reset sel", q, 32'h0);
        end_of_test();
    end

    function automatic logic rpi_okay();
        return rtpi_pkg::HRESP_OKAY;
    endfunction
endmodule
